/* config_decode_pkg.sv */
/*
 * constants for the configuration word decoder: register addresses,
 * field positions, codes and reset values.
 * assumes a 16-bit register port with 24-bit byte addresses.
 */
package config_decode_pkg;
   // register port widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   // register addresses, config words at their printed offsets
   localparam logic [23:0] SUPERVISOR_ADDR = 24'h300002;
   localparam logic [23:0] WATCHDOG_ADDR = 24'h300004;
   localparam logic [23:0] CONTROL_ADDR = 24'h300010;
   localparam logic [23:0] UNLOCK_ADDR = 24'h300012;
   localparam logic [23:0] STATUS_ADDR = 24'h300014;
   // supervisor word field positions
   localparam int EXT_INSTR_N_BIT = 15;
   localparam int DEBUG_N_BIT = 13;
   localparam int STACK_RST_BIT = 12;
   localparam int PS_ONE_WAY_BIT = 11;
   localparam int ZC_DIS_BIT = 10;
   localparam int BOR_THR_LSB = 8;
   localparam int BOR_MODE_LSB = 6;
   localparam int LPBOR_N_BIT = 5;
   localparam int PWRUP_N_BIT = 1;
   localparam int MASTER_CLEAR_EN_BIT = 0;
   localparam logic [15:0] SUPERVISOR_MASK = 16'hBFE3;
   // watchdog word field positions
   localparam int WD_CLK_LSB = 11;
   localparam int WD_WIN_LSB = 8;
   localparam int WD_MODE_LSB = 5;
   localparam logic [15:0] WATCHDOG_MASK = 16'h3FFF;
   // control register bits and reset value
   localparam int CTL_BOR_SW_BIT = 0;
   localparam int CTL_WD_SW_BIT = 1;
   localparam int CTL_ZC_SW_BIT = 2;
   localparam int CTL_ZC_MDIS_BIT = 3;
   localparam int CTL_LOCK_BIT = 4;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   // status register bits
   localparam int ST_UNLOCKED_BIT = 0;
   localparam int ST_LOCKED_BIT = 1;
   localparam int ST_ZC_ON_BIT = 2;
   localparam int ST_BOR_ON_BIT = 3;
   localparam int ST_WD_RUN_BIT = 4;
   // unlock keys, two consecutive writes
   localparam logic [15:0] UNLOCK_KEY1 = 16'h0055;
   localparam logic [15:0] UNLOCK_KEY2 = 16'h00AA;
   // brown-out and watchdog mode codes
   localparam logic [1:0] MODE_ALWAYS = 2'h3;
   localparam logic [1:0] MODE_AWAKE = 2'h2;
   localparam logic [1:0] MODE_SOFTWARE = 2'h1;
   localparam logic [1:0] MODE_OFF = 2'h0;
   // oscillator mode codes
   localparam logic [2:0] OSC_EC_HIGH = 3'h7;
   localparam logic [2:0] OSC_EC_MID = 3'h6;
   localparam logic [2:0] OSC_EC_LOW = 3'h5;
   localparam logic [2:0] OSC_NONE = 3'h4;
   localparam logic [2:0] OSC_HS = 3'h2;
   localparam logic [2:0] OSC_XT = 3'h1;
   localparam logic [2:0] OSC_LP = 3'h0;
   // oscillator range codes on the range output
   localparam logic [1:0] RANGE_LOW = 2'h0;
   localparam logic [1:0] RANGE_MID = 2'h1;
   localparam logic [1:0] RANGE_HIGH = 2'h2;
   // watchdog clock and window codes
   localparam logic [2:0] WD_CLK_SW_CODE = 3'h7;
   localparam logic [2:0] WD_CLK_MID_CODE = 3'h1;
   localparam logic [2:0] WIN_SW_CODE = 3'h7;
   localparam logic [2:0] WIN_KEYED_MAX = 3'h3;
   // decoded watchdog clock choice
   typedef enum logic [1:0] {WD_CLK_LOW, WD_CLK_MID, WD_CLK_SOFTWARE} wd_clk_t;
endpackage

/* supervisor_decode.sv */
/*
 * combinational decode of the supervisor configuration word.
 * assumes word and low-voltage programming flag are stable nvm data.
 */
`timescale 1ns/10ps
module supervisor_decode (
   // raw nvm data
   input wire logic [15:0] word_i,
   input wire logic lvp_i,
   // decoded fields
   output logic ext_instr_en_o,
   output logic debugger_en_o,
   output logic stack_reset_en_o,
   output logic ps_one_way_o,
   output logic zc_forced_on_o,
   output logic [1:0] bor_threshold_o,
   output logic [1:0] bor_mode_o,
   output logic lp_bor_en_o,
   output logic pwrup_en_o,
   output logic master_clear_o
);
   import config_decode_pkg::*;
   // masked word, unused bits never reach the fields
   logic [15:0] w;
   assign w = word_i & SUPERVISOR_MASK;
   // cleared bit enables extended set
   assign ext_instr_en_o = ~w[EXT_INSTR_N_BIT];
   // debugger enable is active low
   assign debugger_en_o = ~w[DEBUG_N_BIT];
   assign stack_reset_en_o = w[STACK_RST_BIT];
   assign ps_one_way_o = w[PS_ONE_WAY_BIT];
   // cleared bit forces detector on
   assign zc_forced_on_o = ~w[ZC_DIS_BIT];
   // threshold code passed as trip level select
   assign bor_threshold_o = w[BOR_THR_LSB +: 2];
   assign bor_mode_o = w[BOR_MODE_LSB +: 2];
   assign lp_bor_en_o = ~w[LPBOR_N_BIT];
   assign pwrup_en_o = ~w[PWRUP_N_BIT];
   // low-voltage programming overrides the pin choice
   assign master_clear_o = lvp_i | w[MASTER_CLEAR_EN_BIT];
endmodule

/* watchdog_osc_decode.sv */
/*
 * combinational decode of the watchdog word and external oscillator mode.
 * assumes stable nvm data at its inputs.
 */
`timescale 1ns/10ps
module watchdog_osc_decode (
   // raw nvm data
   input wire logic [15:0] word_i,
   input wire logic [2:0] osc_mode_i,
   // watchdog fields
   output logic [1:0] wd_mode_o,
   output config_decode_pkg::wd_clk_t wd_clk_o,
   output logic [2:0] win_reset_o,
   output logic win_sw_ctrl_o,
   output logic win_keyed_o,
   // oscillator fields
   output logic osc_enable_o,
   output logic osc_ext_clock_o,
   output logic [1:0] osc_range_o
);
   import config_decode_pkg::*;
   logic [15:0] w; // masked word
   logic [2:0] clk_code; // raw clock source
   assign w = word_i & WATCHDOG_MASK;
   assign wd_mode_o = w[WD_MODE_LSB +: 2];
   assign clk_code = w[WD_CLK_LSB +: 3];
   assign win_reset_o = w[WD_WIN_LSB +: 3];
   assign win_sw_ctrl_o = (win_reset_o == WIN_SW_CODE);
   assign win_keyed_o = (win_reset_o <= WIN_KEYED_MAX);
   // clock source choice, reserved codes fall to low oscillator
   always_comb begin
      if (wd_mode_o == MODE_OFF) begin
         wd_clk_o = WD_CLK_LOW; // field has no effect
      end else if (clk_code == WD_CLK_SW_CODE) begin
         wd_clk_o = WD_CLK_SOFTWARE;
      end else if (clk_code == WD_CLK_MID_CODE) begin
         wd_clk_o = WD_CLK_MID;
      end else begin
         wd_clk_o = WD_CLK_LOW;
      end
   end
   // oscillator kind and range
   always_comb begin
      osc_enable_o = 1'b1;
      osc_ext_clock_o = 1'b0;
      osc_range_o = RANGE_LOW;
      unique case (osc_mode_i)
         OSC_EC_HIGH: begin
            osc_ext_clock_o = 1'b1;
            osc_range_o = RANGE_HIGH;
         end
         OSC_EC_MID: begin
            osc_ext_clock_o = 1'b1;
            osc_range_o = RANGE_MID;
         end
         OSC_EC_LOW: begin
            osc_ext_clock_o = 1'b1;
         end
         OSC_HS: osc_range_o = RANGE_HIGH;
         OSC_XT: osc_range_o = RANGE_MID;
         OSC_LP: osc_range_o = RANGE_LOW;
         default: osc_enable_o = 1'b0; // off and reserved
      endcase
   end
endmodule

/* config_word_supervisor_wdt_decode.sv */
/*
 * configuration word decoder: latches supervisor, watchdog and oscillator
 * settings at reset and drives static and run-time control outputs.
 * assumes nvm words, sleep and stack fault come from logic on ref_clk_i.
 */
// What this block does
// - ext clock codes pick high, mid, low
// - code 100 disables oscillator; 011 reserved
// - crystal codes pick high, mid, low-power
// - bit 15 low enables extended instructions
// - bit 13 low enables debugger
// - bit 12 makes stack faults reset
// - one-way bit makes lock flag sticky
// - zero-cross forced on unless bit 10
// - bits 9:8 pick brown-out trip level
// - modes 11,10 ignore software brown-out enable
// - mode 01 software decides, 00 off
// - bit 5 low enables low-power brown-out
// - bit 1 low enables power-up timer
// - low-voltage programming forces master clear
// - watchdog off makes clock source irrelevant
// - clock source 111 sw, 001 mid, else low
// - window field gives reset window, access
// - watchdog mode 11 always runs
// - watchdog mode 10 pauses in sleep
// - mode 01 software decides, 00 off
`timescale 1ns/10ps
module config_word_supervisor_wdt_decode (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [config_decode_pkg::ADDR_W-1:0] addr_i,
   input wire logic [config_decode_pkg::DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [config_decode_pkg::DATA_W-1:0] rd_data_o,
   // nvm contents
   input wire logic [15:0] supervisor_word_i,
   input wire logic [15:0] watchdog_word_i,
   input wire logic [2:0] external_oscillator_mode_i,
   input wire logic low_voltage_programming_enable_i,
   // nvm programming request
   output logic nvm_prog_o,
   output logic nvm_prog_watchdog_o,
   output logic [15:0] nvm_prog_data_o,
   // run-time inputs
   input wire logic sleep_i,
   input wire logic stack_fault_i,
   // static settings
   output logic extended_instruction_enable_o,
   output logic debugger_enable_o,
   output logic [1:0] brownout_threshold_select_o,
   output logic low_power_brownout_enable_o,
   output logic powerup_timer_enable_o,
   output logic master_clear_o,
   output config_decode_pkg::wd_clk_t watchdog_clock_source_o,
   output logic [2:0] watchdog_window_reset_o,
   output logic watchdog_window_sw_ctrl_o,
   output logic watchdog_window_keyed_o,
   output logic osc_enable_o,
   output logic osc_ext_clock_o,
   output logic [1:0] osc_range_o,
   // run-time controls
   output logic stack_fault_reset_o,
   output logic pin_select_lock_flag_o,
   output logic zero_cross_on_o,
   output logic brownout_active_o,
   output logic watchdog_run_o
);
   import config_decode_pkg::*;

   // unlock sequencer states
   typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_HALF, UNLOCK_OPEN} unlock_t;

   // whole state of the block
   typedef struct packed {
      logic [15:0] sup_word; // latched masked word
      logic [15:0] wd_word; // latched masked word
      logic [1:0] bor_mode; // brown-out mode
      logic [1:0] wd_mode; // watchdog mode
      logic stack_en; // stack fault reset enable
      logic ps_one_way; // one-way lock
      logic zc_forced; // detector forced on
      logic [15:0] control; // software control bits
      unlock_t unlock; // unlock sequence
      logic [15:0] rd_data;
      logic nvm_prog;
      logic nvm_prog_wd;
      logic [15:0] nvm_data;
      logic ext_instr;
      logic debugger;
      logic [1:0] bor_thr;
      logic lp_bor;
      logic pwrup;
      logic master_clear;
      wd_clk_t wd_clk;
      logic [2:0] win_reset;
      logic win_sw;
      logic win_keyed;
      logic osc_en;
      logic osc_ext;
      logic [1:0] osc_range;
      logic stack_reset;
      logic locked;
      logic zc_on;
      logic bor_on;
      logic wd_run;
   } state_t;

   state_t st_reg; // registered state
   state_t st_next; // next state

   // decoder outputs
   logic d_ext_instr;
   logic d_debugger;
   logic d_stack_en;
   logic d_one_way;
   logic d_zc_forced;
   logic [1:0] d_bor_thr;
   logic [1:0] d_bor_mode;
   logic d_lp_bor;
   logic d_pwrup;
   logic d_master_clear;
   logic [1:0] d_wd_mode;
   wd_clk_t d_wd_clk;
   logic [2:0] d_win;
   logic d_win_sw;
   logic d_win_keyed;
   logic d_osc_en;
   logic d_osc_ext;
   logic [1:0] d_osc_range;
   logic lock_req; // lock bit of a control write

   // supervisor word fields
   supervisor_decode u_sup (
      .word_i(supervisor_word_i),
      .lvp_i(low_voltage_programming_enable_i),
      .ext_instr_en_o(d_ext_instr),
      .debugger_en_o(d_debugger),
      .stack_reset_en_o(d_stack_en),
      .ps_one_way_o(d_one_way),
      .zc_forced_on_o(d_zc_forced),
      .bor_threshold_o(d_bor_thr),
      .bor_mode_o(d_bor_mode),
      .lp_bor_en_o(d_lp_bor),
      .pwrup_en_o(d_pwrup),
      .master_clear_o(d_master_clear)
   );

   // watchdog word and oscillator fields
   watchdog_osc_decode u_wd (
      .word_i(watchdog_word_i),
      .osc_mode_i(external_oscillator_mode_i),
      .wd_mode_o(d_wd_mode),
      .wd_clk_o(d_wd_clk),
      .win_reset_o(d_win),
      .win_sw_ctrl_o(d_win_sw),
      .win_keyed_o(d_win_keyed),
      .osc_enable_o(d_osc_en),
      .osc_ext_clock_o(d_osc_ext),
      .osc_range_o(d_osc_range)
   );

   assign lock_req = wr_data_i[CTL_LOCK_BIT];

   // next state: reset load, register port, run-time controls
   always_comb begin
      st_next = st_reg;
      st_next.nvm_prog = 1'b0;
      st_next.stack_reset = 1'b0;
      st_next.rd_data = '0;
      if (rst_i) begin
         // capture all decoded fields once, hold until next reset
         st_next = '0;
         st_next.sup_word = supervisor_word_i & SUPERVISOR_MASK;
         st_next.wd_word = watchdog_word_i & WATCHDOG_MASK;
         st_next.bor_mode = d_bor_mode;
         st_next.wd_mode = d_wd_mode;
         st_next.stack_en = d_stack_en;
         st_next.ps_one_way = d_one_way;
         st_next.zc_forced = d_zc_forced;
         st_next.control = CONTROL_RESET;
         st_next.unlock = UNLOCK_IDLE;
         st_next.ext_instr = d_ext_instr;
         st_next.debugger = d_debugger;
         st_next.bor_thr = d_bor_thr;
         st_next.lp_bor = d_lp_bor;
         st_next.pwrup = d_pwrup;
         st_next.master_clear = d_master_clear;
         st_next.wd_clk = d_wd_clk;
         st_next.win_reset = d_win;
         st_next.win_sw = d_win_sw;
         st_next.win_keyed = d_win_keyed;
         st_next.osc_en = d_osc_en;
         st_next.osc_ext = d_osc_ext;
         st_next.osc_range = d_osc_range;
      end else begin
         // register writes
         if (wr_i) begin
            if (addr_i == SUPERVISOR_ADDR || addr_i == WATCHDOG_ADDR) begin
               // new words go to nvm, take effect at next reset
               st_next.nvm_prog = 1'b1;
               st_next.nvm_prog_wd = (addr_i == WATCHDOG_ADDR);
               st_next.nvm_data = wr_data_i;
            end
            if (addr_i == UNLOCK_ADDR) begin
               // two keys back to back open the lock flag
               if (st_reg.unlock == UNLOCK_HALF && wr_data_i == UNLOCK_KEY2) begin
                  st_next.unlock = UNLOCK_OPEN;
               end else if (wr_data_i == UNLOCK_KEY1) begin
                  st_next.unlock = UNLOCK_HALF;
               end else begin
                  st_next.unlock = UNLOCK_IDLE;
               end
            end else begin
               // any other write breaks or consumes the sequence
               st_next.unlock = UNLOCK_IDLE;
            end
            if (addr_i == CONTROL_ADDR) begin
               st_next.control = wr_data_i;
               st_next.control[CTL_LOCK_BIT] = 1'b0;
               if (st_reg.unlock == UNLOCK_OPEN) begin
                  if (st_reg.ps_one_way) begin
                     // set once, never cleared
                     st_next.locked = st_reg.locked | lock_req;
                  end else begin
                     // free set and clear
                     st_next.locked = lock_req;
                  end
               end
            end
         end
         // register reads, data one cycle later
         if (rd_i) begin
            unique case (addr_i)
               SUPERVISOR_ADDR: st_next.rd_data = st_reg.sup_word;
               WATCHDOG_ADDR: st_next.rd_data = st_reg.wd_word;
               CONTROL_ADDR: st_next.rd_data = st_reg.control;
               STATUS_ADDR: begin
                  st_next.rd_data[ST_UNLOCKED_BIT] = (st_reg.unlock == UNLOCK_OPEN);
                  st_next.rd_data[ST_LOCKED_BIT] = st_reg.locked;
                  st_next.rd_data[ST_ZC_ON_BIT] = st_reg.zc_on;
                  st_next.rd_data[ST_BOR_ON_BIT] = st_reg.bor_on;
                  st_next.rd_data[ST_WD_RUN_BIT] = st_reg.wd_run;
               end
               default: st_next.rd_data = '0; // unmapped reads zero
            endcase
         end
         // stack fault reset request
         st_next.stack_reset = stack_fault_i & st_reg.stack_en;
         // zero-cross: forced on ignores module disable
         if (st_reg.zc_forced) begin
            st_next.zc_on = 1'b1;
         end else begin
            st_next.zc_on = st_reg.control[CTL_ZC_SW_BIT] &
                            ~st_reg.control[CTL_ZC_MDIS_BIT];
         end
         // brown-out reset activity
         unique case (st_reg.bor_mode)
            MODE_ALWAYS: st_next.bor_on = 1'b1;
            MODE_AWAKE: st_next.bor_on = ~sleep_i;
            MODE_SOFTWARE: st_next.bor_on = st_reg.control[CTL_BOR_SW_BIT];
            MODE_OFF: st_next.bor_on = 1'b0;
         endcase
         // watchdog activity
         unique case (st_reg.wd_mode)
            MODE_ALWAYS: st_next.wd_run = 1'b1;
            MODE_AWAKE: st_next.wd_run = ~sleep_i;
            MODE_SOFTWARE: st_next.wd_run = st_reg.control[CTL_WD_SW_BIT];
            MODE_OFF: st_next.wd_run = 1'b0;
         endcase
      end
   end

   // state register, reset handled above
   always_ff @(posedge ref_clk_i) begin
      st_reg <= st_next;
   end

   // outputs straight from the state register
   assign rd_data_o = st_reg.rd_data;
   assign nvm_prog_o = st_reg.nvm_prog;
   assign nvm_prog_watchdog_o = st_reg.nvm_prog_wd;
   assign nvm_prog_data_o = st_reg.nvm_data;
   assign extended_instruction_enable_o = st_reg.ext_instr;
   assign debugger_enable_o = st_reg.debugger;
   assign brownout_threshold_select_o = st_reg.bor_thr;
   assign low_power_brownout_enable_o = st_reg.lp_bor;
   assign powerup_timer_enable_o = st_reg.pwrup;
   assign master_clear_o = st_reg.master_clear;
   assign watchdog_clock_source_o = st_reg.wd_clk;
   assign watchdog_window_reset_o = st_reg.win_reset;
   assign watchdog_window_sw_ctrl_o = st_reg.win_sw;
   assign watchdog_window_keyed_o = st_reg.win_keyed;
   assign osc_enable_o = st_reg.osc_en;
   assign osc_ext_clock_o = st_reg.osc_ext;
   assign osc_range_o = st_reg.osc_range;
   assign stack_fault_reset_o = st_reg.stack_reset;
   assign pin_select_lock_flag_o = st_reg.locked;
   assign zero_cross_on_o = st_reg.zc_on;
   assign brownout_active_o = st_reg.bor_on;
   assign watchdog_run_o = st_reg.wd_run;

   // checks on the decoded behaviour
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // key pair then lock write, whether or not already locked
   sequence s_key_pair;
      wr_i && addr_i == UNLOCK_ADDR && wr_data_i == UNLOCK_KEY1
      ##1 wr_i && addr_i == UNLOCK_ADDR && wr_data_i == UNLOCK_KEY2;
   endsequence
   sequence s_lock_write;
      wr_i && addr_i == CONTROL_ADDR && lock_req;
   endsequence

   a_lock_unlock_set: assert property (
      s_key_pair ##1 s_lock_write |=> pin_select_lock_flag_o)
      else $error("lock flag not set after unlock sequence");
   a_lock_one_way: assert property (
      st_reg.ps_one_way && pin_select_lock_flag_o |=> pin_select_lock_flag_o)
      else $error("one-way lock flag cleared");
   a_lock_no_key: assert property (
      st_reg.unlock != UNLOCK_OPEN |=> $stable(pin_select_lock_flag_o))
      else $error("lock flag changed without unlock");
   a_stack_fault_reset: assert property (
      stack_fault_i |=> stack_fault_reset_o == st_reg.stack_en)
      else $error("stack fault reset mismatch");
   a_bor_always_on: assert property (
      st_reg.bor_mode == MODE_ALWAYS |=> brownout_active_o)
      else $error("brown-out not active in always mode");
   a_bor_sleep_off: assert property (
      st_reg.bor_mode == MODE_AWAKE && sleep_i |=> !brownout_active_o)
      else $error("brown-out active in sleep");
   a_bor_software: assert property (
      st_reg.bor_mode == MODE_SOFTWARE
      |=> brownout_active_o == $past(st_reg.control[CTL_BOR_SW_BIT]))
      else $error("brown-out does not follow software bit");
   a_wd_always_run: assert property (
      st_reg.wd_mode == MODE_ALWAYS |=> watchdog_run_o)
      else $error("watchdog stopped in always mode");
   a_wd_sleep_pause: assert property (
      st_reg.wd_mode == MODE_AWAKE && sleep_i |=> !watchdog_run_o)
      else $error("watchdog runs in sleep");
   a_wd_off_mode: assert property (
      st_reg.wd_mode == MODE_OFF |-> ##1 !watchdog_run_o
      && watchdog_clock_source_o == WD_CLK_LOW)
      else $error("watchdog active while disabled");
   a_zc_forced_on: assert property (
      st_reg.zc_forced |=> zero_cross_on_o)
      else $error("zero-cross off while forced on");
   a_config_hold: assert property (
      ##1 $stable(extended_instruction_enable_o) && $stable(watchdog_window_reset_o)
      && $stable(master_clear_o) && $stable(osc_range_o))
      else $error("static configuration changed after reset");
endmodule

/* config_word_supervisor_wdt_decode_test.sv */
/* self-checking bench for the configuration word decoder.
   assumes config_decode_pkg and the design files are compiled first. */
`timescale 1ns/10ps
`define check(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module config_word_supervisor_wdt_decode_test;
   import config_decode_pkg::*;
   // stimulus and observed outputs
   logic ref_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, low_voltage_programming_enable = 0, sleep = 0, fault = 0;
   logic [23:0] addr = 0;
   logic [15:0] wdat = 0, sup = 0, wdw = 0, rdat, pdata;
   logic [2:0] osc = 0, win;
   logic [1:0] thr, rng;
   wd_clk_t clk_src;
   logic xi, dbg, lpb, pwr, master_clear, wsw, wky, oen, oext, prog, progw, sfr, lock, zc, bor, wdr;
   int errors = 0, n_tests = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   config_word_supervisor_wdt_decode dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .addr_i(addr), .wr_data_i(wdat), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rdat),
      .supervisor_word_i(sup), .watchdog_word_i(wdw), .external_oscillator_mode_i(osc),
      .low_voltage_programming_enable_i(low_voltage_programming_enable), .nvm_prog_o(prog),
      .nvm_prog_watchdog_o(progw), .nvm_prog_data_o(pdata), .sleep_i(sleep),
      .stack_fault_i(fault), .extended_instruction_enable_o(xi), .debugger_enable_o(dbg),
      .brownout_threshold_select_o(thr), .low_power_brownout_enable_o(lpb),
      .powerup_timer_enable_o(pwr), .master_clear_o(master_clear), .watchdog_clock_source_o(clk_src),
      .watchdog_window_reset_o(win), .watchdog_window_sw_ctrl_o(wsw),
      .watchdog_window_keyed_o(wky), .osc_enable_o(oen), .osc_ext_clock_o(oext),
      .osc_range_o(rng), .stack_fault_reset_o(sfr), .pin_select_lock_flag_o(lock),
      .zero_cross_on_o(zc), .brownout_active_o(bor), .watchdog_run_o(wdr));
   // verdict, reached from the main sequence or the timeout
   task automatic conclude;
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // new nvm contents, then reset for n edges
   task automatic restart(input logic [15:0] s, w, input logic [2:0] o, input logic l,
                          input int n);
      @(posedge ref_clk_i);
      sup <= s;
      wdw <= w;
      osc <= o;
      low_voltage_programming_enable <= l;
      sleep <= 0;
      rst_i <= 1;
      repeat (n) @(posedge ref_clk_i);
      rst_i <= 0;
      @(posedge ref_clk_i);
      #1;
   endtask
   // one-cycle register write
   task automatic wr(input logic [23:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      wdat <= d;
      wr_i <= 1;
      @(posedge ref_clk_i);
      wr_i <= 0;
      #1;
   endtask
   // key pair and control write on three consecutive edges, no gap
   task automatic keyed_write(input logic [15:0] d);
      @(posedge ref_clk_i);
      addr <= UNLOCK_ADDR;
      wdat <= UNLOCK_KEY1;
      wr_i <= 1;
      @(posedge ref_clk_i);
      wdat <= UNLOCK_KEY2;
      @(posedge ref_clk_i);
      addr <= CONTROL_ADDR;
      wdat <= d;
      @(posedge ref_clk_i);
      wr_i <= 0;
      #1;
   endtask
   // one-cycle read, data judged in the following cycle
   task automatic rd(input logic [23:0] a, input logic [15:0] e);
      @(posedge ref_clk_i);
      addr <= a;
      rd_i <= 1;
      @(posedge ref_clk_i);
      rd_i <= 0;
      #1;
      `check(rdat, e)
   endtask
   task automatic settle;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask
   // every oscillator code but reserved 011, varied supervisor and watchdog words
   task automatic static_decode;
      logic [15:0] s, w;
      wd_clk_t ec;
      for (int i = 0; i < 8; i++) begin
         s = 16'h5A5A ^ (16'(i) * 16'h1357);
         // fast external clock gets the highest trip voltage
         if (i == 7) s[9:8] = 2'b00;
         w = 16'hC01F | (16'(i) << 11) | (16'(7 - i) << 8) | (16'((i + 1) >> 1 & 3) << 5);
         ec = (w[6:5] == 0 || !(i == 7 || i == 1)) ? WD_CLK_LOW :
              (i == 7 ? WD_CLK_SOFTWARE : WD_CLK_MID);
         // reserved oscillator code is never programmed, off code instead
         restart(s, w, (i == 3) ? OSC_NONE : 3'(i), i[0], 2);
         `check(xi, ~s[15])
         `check(dbg, ~s[13])
         `check(thr, s[9:8])
         `check(lpb, ~s[5])
         `check(pwr, ~s[1])
         `check(master_clear, i[0] | s[0])
         `check(clk_src, ec)
         `check(win, w[10:8])
         `check(wsw, w[10:8] == 7)
         `check(wky, w[10:8] <= 3)
         `check(oen, !(i == 4 || i == 3))
         `check(oext, i >= 5)
         if (i != 3 && i != 4) `check(rng, 2'(i % 5))
         rd(SUPERVISOR_ADDR, s & SUPERVISOR_MASK);
         rd(WATCHDOG_ADDR, w & WATCHDOG_MASK);
      end
   endtask
   // all mode codes against software enables, sleep and zero-cross disable
   task automatic dynamic_modes;
      logic [1:0] m;
      logic sw, sl, eb, ez;
      for (int i = 0; i < 32; i++) begin
         m = 2'(i);
         sw = i[2];
         sl = i[3];
         restart({5'h0, i[4], 2'h0, m, 6'h0}, {2'h0, 3'h7, 4'h0, m, 5'h0}, 3'h2, 0, 2);
         wr(CONTROL_ADDR, {12'h0, sl, sw, sw, sw});
         @(posedge ref_clk_i);
         sleep <= sl;
         settle;
         eb = m == 3 || (m == 2 && !sl) || (m == 1 && sw);
         ez = !i[4] || (sw && !sl);
         `check(bor, eb)
         `check(wdr, eb)
         `check(zc, ez)
         `check(clk_src, m != 0 ? WD_CLK_SOFTWARE : WD_CLK_LOW)
         rd(STATUS_ADDR, {11'h0, eb, eb, ez, 2'h0});
      end
   endtask
   // lock request with and without the key sequence, then a clear attempt
   task automatic lock_seq(input logic one_way);
      restart({4'h0, one_way, 11'h0}, 16'h0, 3'h2, 0, 2);
      wr(CONTROL_ADDR, 16'h0013);
      settle;
      `check(lock, 1'b0)
      rd(CONTROL_ADDR, 16'h0003);
      for (int k = 1; k >= 0; k--) begin
         if (k == 1) begin
            keyed_write(16'h0010);
         end else begin
            wr(UNLOCK_ADDR, UNLOCK_KEY1);
            wr(UNLOCK_ADDR, UNLOCK_KEY2);
            wr(CONTROL_ADDR, 16'h0000);
         end
         settle;
         `check(lock, k[0] | one_way)
      end
      if (one_way) rd(STATUS_ADDR, 16'h0006);
   endtask
   // stack fault reset both ways, then config write leaves decode alone
   task automatic fault_and_prog;
      for (int e = 1; e >= 0; e--) begin
         restart(16'(e) << 12, 16'h0, 3'h2, 0, 2);
         @(posedge ref_clk_i);
         fault <= 1;
         @(posedge ref_clk_i);
         fault <= 0;
         #1;
         `check(sfr, e[0])
      end
      wr(WATCHDOG_ADDR, 16'h1234);
      `check({prog, progw, pdata}, {2'h3, 16'h1234})
      wr(SUPERVISOR_ADDR, 16'h8001);
      `check({prog, progw, pdata}, {2'h2, 16'h8001})
      @(posedge ref_clk_i);
      sup <= 16'hFFFF;
      settle;
      `check({prog, xi, dbg, win}, {1'b0, 1'b1, 1'b1, 3'h0})
      rd(24'h300020, 16'h0000);
   endtask
   initial begin
      restart(16'hFCFF, 16'hFFFF, 3'h7, 1, 10);
      static_decode;
      dynamic_modes;
      lock_seq(1);
      lock_seq(0);
      fault_and_prog;
      conclude;
   end
   // hang guard
   initial begin
      #500000;
      errors++;
      conclude;
   end
endmodule
